/* File: src/tpff_pkg.sv */
// constants, register map and carrier types of the tx packet field framer
// assumes one 200 MHz clock domain and an AHB-Lite register bus
package tpff_pkg;
    // register indices as printed; byte address = index * 4
    localparam logic [7:0] IDX_DATA_CTRL = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    localparam logic [7:0] IDX_HDR_CTRL = 8'h33;
    localparam logic [7:0] IDX_PRE_LEN = 8'h34;
    localparam logic [7:0] IDX_SYNC3 = 8'h36;
    localparam logic [7:0] IDX_SYNC2 = 8'h37;
    localparam logic [7:0] IDX_SYNC1 = 8'h38;
    localparam logic [7:0] IDX_SYNC0 = 8'h39;
    localparam logic [7:0] IDX_HDR3 = 8'h3a;
    localparam logic [7:0] IDX_HDR2 = 8'h3b;
    localparam logic [7:0] IDX_HDR1 = 8'h3c;
    localparam logic [7:0] IDX_HDR0 = 8'h3d;
    localparam logic [7:0] IDX_PAY_LEN = 8'h3e;
    localparam logic [7:0] IDX_START = 8'h40;
    // reset values
    localparam logic [7:0] RST_PRE_LEN = 8'h08;
    localparam logic [7:0] RST_SYNC3 = 8'h2d;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // field positions
    localparam int BIT_ENPAC = 3;
    localparam int BIT_PRE_MSB = 0;
    localparam int LSB_SYNC_LEN = 1;
    localparam int BIT_FIX_LEN = 3;
    localparam int LSB_HDR_LEN = 4;
    localparam int BIT_BUSY = 1;
    localparam int BIT_SENT = 0;
    localparam int BIT_GO = 0;
    localparam logic [2:0] HDR_LEN_MAX = 3'h4;
    localparam logic [3:0] PREAMBLE_NIB = 4'ha;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [8:0] PRE_ONE = 9'h001;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_PRE = 7'b000_0010,
        ST_SYNC = 7'b000_0100,
        ST_HDR = 7'b000_1000,
        ST_LEN = 7'b001_0000,
        ST_PAY = 7'b010_0000,
        ST_DONE = 7'b100_0000
    } tpff_state_type;

    // one symbol of the framed stream
    typedef struct packed {
        logic last;
        logic [3:0] nib;
    } tpff_sym_type;
endpackage

/* File: src/tpff_top.sv */
// tx packet field framer: ahb-lite register slave, field sequencer, two-entry output buffer
// assumes the payload source and the nibble sink share i_clk; payload bytes arrive by valid/ready
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module tpff_top #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_pay_valid,
    input wire logic [7:0] i_pay_data,
    output logic o_pay_ready,
    output logic o_sym_valid,
    output logic [3:0] o_sym_nib,
    output logic o_sym_last,
    input wire logic i_sym_ready,
    output logic o_busy
);
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    // refused at elaboration: the shift buffer needs a second slot to absorb a stall
    if (BUF_DEPTH < 2) begin
        $error("BUF_DEPTH must be at least 2");
    end

    function automatic logic [7:0] pick_byte(input logic [31:0] word, input logic [1:0] idx);
        pick_byte = word[{idx, 3'b000} +: 8];
    endfunction

    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // registers
    logic [7:0] data_ctrl_ff;
    logic [7:0] hdr_ctrl_ff;
    logic [7:0] pre_len_ff;
    logic [31:0] sync_ff;
    logic [31:0] hdr_ff;
    logic [7:0] pay_len_ff;
    logic sent_ff;
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic go_pulse;
    tpff_pkg::tpff_state_type state_ff;

    wire logic addr_ok = i_hsel && i_hready && i_htrans == tpff_pkg::HTRANS_NONSEQ;
    wire logic [7:0] addr_idx = (i_haddr[31:10] == 22'h00_0000) ? i_haddr[9:2] : 8'hff;
    wire logic [7:0] wbyte = i_hwdata[7:0];

    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && i_hwrite;
            wr_idx_ff <= addr_idx;
        end
    end

    assign go_pulse = wr_pend_ff && wr_idx_ff == tpff_pkg::IDX_START && wbyte[tpff_pkg::BIT_GO]
        && data_ctrl_ff[tpff_pkg::BIT_ENPAC] && state_ff == tpff_pkg::ST_IDLE;

    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            data_ctrl_ff <= tpff_pkg::RST_ZERO;
            hdr_ctrl_ff <= tpff_pkg::RST_ZERO;
            pre_len_ff <= tpff_pkg::RST_PRE_LEN;
            sync_ff <= {tpff_pkg::RST_SYNC3, tpff_pkg::RST_ZERO, tpff_pkg::RST_ZERO, tpff_pkg::RST_ZERO};
            hdr_ff <= 32'h0000_0000;
            pay_len_ff <= tpff_pkg::RST_ZERO;
        end else if (wr_pend_ff) begin
            unique case (wr_idx_ff)
                tpff_pkg::IDX_DATA_CTRL: data_ctrl_ff <= wbyte;
                tpff_pkg::IDX_HDR_CTRL: hdr_ctrl_ff <= {1'b0, wbyte[6:0]};
                tpff_pkg::IDX_PRE_LEN: pre_len_ff <= wbyte;
                tpff_pkg::IDX_SYNC3: sync_ff[31:24] <= wbyte;
                tpff_pkg::IDX_SYNC2: sync_ff[23:16] <= wbyte;
                tpff_pkg::IDX_SYNC1: sync_ff[15:8] <= wbyte;
                tpff_pkg::IDX_SYNC0: sync_ff[7:0] <= wbyte;
                tpff_pkg::IDX_HDR3: hdr_ff[31:24] <= wbyte;
                tpff_pkg::IDX_HDR2: hdr_ff[23:16] <= wbyte;
                tpff_pkg::IDX_HDR1: hdr_ff[15:8] <= wbyte;
                tpff_pkg::IDX_HDR0: hdr_ff[7:0] <= wbyte;
                tpff_pkg::IDX_PAY_LEN: pay_len_ff <= wbyte;
                default: begin
                end
            endcase
        end
    end

    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        unique case (addr_idx)
            tpff_pkg::IDX_DATA_CTRL: rd_val = data_ctrl_ff;
            tpff_pkg::IDX_STATUS: rd_val = {6'h00, o_busy, sent_ff};
            tpff_pkg::IDX_HDR_CTRL: rd_val = hdr_ctrl_ff;
            tpff_pkg::IDX_PRE_LEN: rd_val = pre_len_ff;
            tpff_pkg::IDX_SYNC3: rd_val = sync_ff[31:24];
            tpff_pkg::IDX_SYNC2: rd_val = sync_ff[23:16];
            tpff_pkg::IDX_SYNC1: rd_val = sync_ff[15:8];
            tpff_pkg::IDX_SYNC0: rd_val = sync_ff[7:0];
            tpff_pkg::IDX_HDR3: rd_val = hdr_ff[31:24];
            tpff_pkg::IDX_HDR2: rd_val = hdr_ff[23:16];
            tpff_pkg::IDX_HDR1: rd_val = hdr_ff[15:8];
            tpff_pkg::IDX_HDR0: rd_val = hdr_ff[7:0];
            tpff_pkg::IDX_PAY_LEN: rd_val = pay_len_ff;
            default: rd_val = 8'h00;
        endcase
    end

    // zero-wait slave: read data prepared during the address phase
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp <= 1'b0;
        end else begin
            o_hrdata <= (addr_ok && !i_hwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // field decode
    wire logic [8:0] pre_len = {hdr_ctrl_ff[tpff_pkg::BIT_PRE_MSB], pre_len_ff};
    wire logic [8:0] pre_nibs = (pre_len == 9'h000) ? tpff_pkg::PRE_ONE : pre_len;
    wire logic [1:0] sync_code = hdr_ctrl_ff[tpff_pkg::LSB_SYNC_LEN +: 2];
    wire logic [2:0] hdr_code = hdr_ctrl_ff[tpff_pkg::LSB_HDR_LEN +: 3];
    // codes above four are clamped to all four headers
    wire logic [2:0] hdr_cnt = (hdr_code > tpff_pkg::HDR_LEN_MAX) ? tpff_pkg::HDR_LEN_MAX : hdr_code;
    wire logic fix_len = hdr_ctrl_ff[tpff_pkg::BIT_FIX_LEN];

    // next field after the current one, skipping empty fields
    function automatic tpff_pkg::tpff_state_type after(input tpff_pkg::tpff_state_type cur,
            input logic [2:0] hc, input logic fx, input logic [7:0] pl);
        tpff_pkg::tpff_state_type res;
        res = tpff_pkg::ST_DONE;
        if (cur == tpff_pkg::ST_PRE) begin
            res = tpff_pkg::ST_SYNC;
        end else if (cur == tpff_pkg::ST_SYNC && hc != 3'h0) begin
            res = tpff_pkg::ST_HDR;
        end else if ((cur == tpff_pkg::ST_SYNC || cur == tpff_pkg::ST_HDR) && !fx) begin
            res = tpff_pkg::ST_LEN;
        end else if (cur != tpff_pkg::ST_PAY && pl != 8'h00) begin
            res = tpff_pkg::ST_PAY;
        end
        after = res;
    endfunction

    logic [8:0] idx_ff;
    logic half_ff;
    logic [7:0] hold_ff;
    logic hold_vld_ff;
    logic [CNT_W-1:0] cnt_ff;
    tpff_pkg::tpff_sym_type ent_ff [BUF_DEPTH];

    logic have_sym;
    logic field_end;
    logic [7:0] cur_byte;
    tpff_pkg::tpff_sym_type sym;
    tpff_pkg::tpff_state_type nxt_field;
    always_comb begin
        nxt_field = after(state_ff, hdr_cnt, fix_len, pay_len_ff);
        cur_byte = 8'h00;
        have_sym = 1'b1;
        field_end = half_ff;
        unique case (state_ff)
            tpff_pkg::ST_PRE: field_end = idx_ff == pre_nibs - 9'h001;
            tpff_pkg::ST_SYNC: begin
                cur_byte = pick_byte(sync_ff, 2'h3 - idx_ff[1:0]);
                field_end = half_ff && idx_ff[1:0] == sync_code;
            end
            tpff_pkg::ST_HDR: begin
                cur_byte = pick_byte(hdr_ff, 2'h3 - idx_ff[1:0]);
                field_end = half_ff && idx_ff[2:0] == hdr_cnt - 3'h1;
            end
            tpff_pkg::ST_LEN: cur_byte = pay_len_ff;
            tpff_pkg::ST_PAY: begin
                cur_byte = hold_ff;
                have_sym = hold_vld_ff;
                field_end = half_ff && idx_ff[7:0] == pay_len_ff - 8'h01;
            end
            default: have_sym = 1'b0;
        endcase
        sym.nib = (state_ff == tpff_pkg::ST_PRE) ? tpff_pkg::PREAMBLE_NIB
            : (half_ff ? cur_byte[3:0] : cur_byte[7:4]);
        sym.last = field_end && nxt_field == tpff_pkg::ST_DONE;
    end

    // back-pressure from the buffer stalls the sequencer
    wire logic pop = o_sym_valid && i_sym_ready;
    wire logic push = have_sym && cnt_ff < CNT_W'(BUF_DEPTH);

    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= tpff_pkg::ST_IDLE;
            idx_ff <= 9'h000;
            half_ff <= 1'b0;
        end else if (go_pulse) begin
            state_ff <= tpff_pkg::ST_PRE;
            idx_ff <= 9'h000;
            half_ff <= 1'b0;
        end else if (state_ff == tpff_pkg::ST_DONE) begin
            state_ff <= tpff_pkg::ST_IDLE;
        end else if (push) begin
            if (field_end) begin
                state_ff <= nxt_field;
                idx_ff <= 9'h000;
                half_ff <= 1'b0;
            end else if (state_ff == tpff_pkg::ST_PRE || half_ff) begin
                idx_ff <= idx_ff + 9'h001;
                half_ff <= 1'b0;
            end else begin
                half_ff <= 1'b1;
            end
        end
    end

    // payload byte holder; ready only while empty in the payload field
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            hold_ff <= 8'h00;
            hold_vld_ff <= 1'b0;
            o_pay_ready <= 1'b0;
        end else begin
            if (o_pay_ready && i_pay_valid) begin
                hold_ff <= i_pay_data;
                hold_vld_ff <= 1'b1;
            end else if (state_ff == tpff_pkg::ST_PAY && push && half_ff) begin
                hold_vld_ff <= 1'b0;
            end
            o_pay_ready <= state_ff == tpff_pkg::ST_PAY && !hold_vld_ff && !(o_pay_ready && i_pay_valid);
        end
    end

    // status
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sent_ff <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            if (state_ff == tpff_pkg::ST_DONE) begin
                sent_ff <= 1'b1;
            end else if (go_pulse) begin
                sent_ff <= 1'b0;
            end
            o_busy <= go_pulse || (state_ff != tpff_pkg::ST_IDLE && state_ff != tpff_pkg::ST_DONE);
        end
    end

    // shift buffer: head entry is always slot 0, so outputs come from flops
    wire logic [CNT_W-1:0] wr_slot = cnt_ff - CNT_W'(pop);
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cnt_ff <= '0;
            o_sym_valid <= 1'b0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                ent_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < BUF_DEPTH - 1; i++) begin
                if (pop) begin
                    ent_ff[i] <= ent_ff[i+1];
                end
            end
            for (int i = 0; i < BUF_DEPTH; i++) begin
                if (push && CNT_W'(i) == wr_slot) begin
                    ent_ff[i] <= sym;
                end
            end
            cnt_ff <= cnt_ff + CNT_W'(push) - CNT_W'(pop);
            o_sym_valid <= (cnt_ff + CNT_W'(push) - CNT_W'(pop)) != '0;
        end
    end

    assign o_sym_nib = ent_ff[0].nib;
    assign o_sym_last = ent_ff[0].last;
endmodule

/* File: tb/tpff_sva.sv */
// port-level checker for the tx packet field framer
// assumes a single bus slave, so hreadyout is the bus hready
`timescale 1ns/1ps
module tpff_sva #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic i_pay_valid,
    input wire logic o_pay_ready,
    input wire logic o_sym_valid,
    input wire logic [3:0] o_sym_nib,
    input wire logic o_sym_last,
    input wire logic i_sym_ready,
    input wire logic o_busy
);
    logic go_ff;
    logic [2:0] up_ff;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            go_ff <= 1'b0;
        end else begin
            go_ff <= i_hsel && o_hreadyout && i_htrans == tpff_pkg::HTRANS_NONSEQ && i_hwrite
                && i_haddr == 32'h0000_0100;
        end
    end
    // edges since release; hreadyout may lag the reset synchroniser
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_ff <= 3'h0;
        end else if (up_ff != 3'h4) begin
            up_ff <= up_ff + 3'h1;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_OKAY: assert property (o_hresp == 1'b0) else $error("error response");
    AST_UPPER: assert property (o_hrdata[31:8] == 24'h00_0000) else $error("read data upper bits set");
    AST_HREADY: assert property (up_ff == 3'h4 |-> o_hreadyout) else $error("slave not ready");
    AST_START: assert property ($rose(o_busy) |-> $past(go_ff && i_hwdata[0]) ||
        $past(go_ff && i_hwdata[0], 2)) else $error("frame began without start");
    AST_PRE_FIRST: assert property ($rose(o_busy) |-> ##[1:4]
        (o_sym_valid && o_sym_nib == tpff_pkg::PREAMBLE_NIB)) else $error("frame not opened by preamble");
    AST_HOLD: assert property (o_sym_valid && !i_sym_ready |=> o_sym_valid && $stable(o_sym_nib)
        && $stable(o_sym_last)) else $error("stalled nibble changed");
    AST_LAST_END: assert property (o_sym_valid && o_sym_last && i_sym_ready |-> ##[0:2] !o_busy)
        else $error("busy after final nibble");
    AST_IDLE: assert property (!o_busy && !o_sym_valid |=> !o_sym_valid)
        else $error("nibble outside a frame");
    AST_PAY_IN_FRAME: assert property (o_pay_ready |-> o_busy)
        else $error("payload taken outside a frame");
    COV_END: cover property ($fell(o_busy));
    COV_STALL: cover property (o_sym_valid && !i_sym_ready);
    COV_PAY: cover property (o_pay_ready && i_pay_valid);
endmodule
bind tpff_top tpff_sva #(.BUF_DEPTH(BUF_DEPTH)) tpff_sva_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_pay_valid(i_pay_valid), .o_pay_ready(o_pay_ready), .o_sym_valid(o_sym_valid),
    .o_sym_nib(o_sym_nib), .o_sym_last(o_sym_last), .i_sym_ready(i_sym_ready), .o_busy(o_busy)
);

/* File: tb/tpff_rx_model.sv */
// receiving radio model: records every framed nibble it takes
// assumes nibbles are taken on valid and ready at i_clk
`timescale 1ns/1ps
module tpff_rx_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [3:0] i_nib,
    input wire logic i_last,
    input wire logic i_slow,
    output logic o_ready,
    output int o_cnt,
    output int o_last_at
);
    logic [3:0] mem [4096];
    // slow mode takes every other cycle so the buffer fills and refuses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready <= 1'b0;
            o_cnt <= 0;
            o_last_at <= -1;
        end else begin
            o_ready <= i_slow ? !o_ready : 1'b1;
            if (i_valid && o_ready) begin
                mem[o_cnt[11:0]] <= i_nib;
                o_cnt <= o_cnt + 1;
                if (i_last) begin
                    o_last_at <= o_cnt;
                end
            end
        end
    end
endmodule

/* File: tb/tpff_tb_top.sv */
// framer testbench: register access over ahb-lite, frames checked nibble by nibble
// assumes the package indices, byte address = index * 4
`timescale 1ns/1ps
module tpff_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic pay_valid = 1'b0;
    logic [7:0] pay_data = 8'h0;
    logic slow = 1'b0;
    logic [31:0] hrdata;
    logic hready, hresp, pay_ready, sym_valid, sym_last, sym_ready, busy;
    logic [3:0] sym_nib;
    int rcnt, rlast;
    int error_cnt = 0;
    int samples_checked = 0;
    int ptgt = 0;
    int pidx = 0;
    logic [3:0] q [$];
    logic [31:0] rdv;
    logic [63:0] sh = 64'hd391_4e27_b86c_35e0;
    tpff_top tpff_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_pay_valid(pay_valid), .i_pay_data(pay_data),
        .o_pay_ready(pay_ready), .o_sym_valid(sym_valid), .o_sym_nib(sym_nib), .o_sym_last(sym_last),
        .i_sym_ready(sym_ready), .o_busy(busy));
    tpff_rx_model tpff_rx_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_valid(sym_valid), .i_nib(sym_nib),
        .i_last(sym_last), .i_slow(slow), .o_ready(sym_ready), .o_cnt(rcnt), .o_last_at(rlast));
    initial begin
        forever #2.5 clk = !clk;
    end
    // payload source; byte value follows its running index
    always @(posedge clk) begin
        if (pay_valid && pay_ready) begin
            pay_valid <= 1'b0;
            pidx <= pidx + 1;
        end else if (pidx < ptgt) begin
            pay_valid <= 1'b1;
            pay_data <= 8'(pidx) ^ 8'h5a;
        end
    end
    task print_verdict;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
        end
    endtask
    task tmo;
        error_cnt++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        print_verdict();
    endtask
    task wait_rdy(output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) tmo();
            @(posedge clk);
        end
        rd = hrdata;
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        htrans <= tpff_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_rdy(rdv);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy(rdv);
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, {22'h0, i, 2'h0}, d);
    endtask
    task rchk(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, {22'h0, i, 2'h0}, 8'h0);
        chk(rdv, {24'h0, e});
    endtask
    task put(input logic [7:0] b);
        q.push_back(b[7:4]);
        q.push_back(b[3:0]);
    endtask
    task s_regs;
        static logic [7:0] rv [7] = '{8'h08, 8'h2d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        static logic [7:0] ix [7] = '{8'h34, 8'h36, 8'h38, 8'h39, 8'h3b, 8'h3c, 8'h3e};
        for (int i = 0; i < 7; i++) rchk(ix[i], rv[i]);
        for (int i = 0; i < 8; i++) wr(8'h36 + 8'(i), sh[63 - 8 * i -: 8]);
        for (int i = 0; i < 8; i++) rchk(8'h36 + 8'(i), sh[63 - 8 * i -: 8]);
        wr(8'h33, 8'hff);
        rchk(8'h33, 8'h7f);
        bus(1'b0, 32'h0000_0400, 8'h0);
        chk(rdv, 32'h0);
    endtask
    task s_off;
        wr(8'h30, 8'h00);
        wr(8'h40, 8'h01);
        repeat (4) @(negedge clk);
        chk(busy, 1'b0);
        chk(rcnt, 0);
        @(posedge clk);
        rchk(8'h31, 8'h00);
    endtask
    task frame(input logic [8:0] p, input logic [1:0] sc, input logic [2:0] hc, input logic fx,
        input logic [7:0] pl, input logic slw, input logic two);
        int base, n, pb;
        q = {};
        wr(8'h34, p[7:0]);
        wr(8'h33, {1'b0, hc, fx, sc, p[8]});
        wr(8'h3e, pl);
        wr(8'h30, 8'h08);
        slow <= slw;
        for (n = 0; n < ((p == 9'h0) ? 1 : int'(p)); n++) q.push_back(tpff_pkg::PREAMBLE_NIB);
        for (n = 0; n <= sc; n++) put(sh[63 - 8 * n -: 8]);
        for (n = 0; n < hc && n < 4; n++) put(sh[31 - 8 * n -: 8]);
        if (!fx) put(pl);
        pb = ptgt;
        for (n = 0; n < pl; n++) put(8'(pb + n) ^ 8'h5a);
        base = rcnt;
        ptgt <= ptgt + pl;
        wr(8'h40, 8'h01);
        if (two) wr(8'h40, 8'h01);
        n = 0;
        while (busy !== 1'b0 || rcnt != base + q.size()) begin
            n++;
            if (n > 9000) tmo();
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
        chk(rcnt, base + q.size());
        for (n = 0; n < q.size(); n++) chk(tpff_rx_model_i.mem[(base + n) % 4096], q[n]);
        chk(rlast, base + q.size() - 1);
        @(posedge clk);
        rchk(8'h31, 8'h01);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        s_regs();
        s_off();
        for (int s = 0; s < 4; s++) begin
            for (int h = 0; h < 6; h++) begin
                frame(9'h1, 2'(s), 3'(h), h[0], 8'h1, 1'b0, 1'b0);
            end
        end
        frame(9'h8, 2'h3, 3'h4, 1'b0, 8'h3, 1'b1, 1'b0);
        frame(9'h0, 2'h0, 3'h0, 1'b1, 8'h0, 1'b0, 1'b0);
        frame(9'h100, 2'h1, 3'h1, 1'b1, 8'h8, 1'b0, 1'b0);
        frame(9'h1ff, 2'h2, 3'h7, 1'b0, 8'hff, 1'b1, 1'b1);
        print_verdict();
    end
endmodule
